// ---- cts_cfg.svh ----
// Timing and layout constants for the camera trigger and sync block
`ifndef CTS_CFG_SVH
`define CTS_CFG_SVH
`define CTS_CLK_HZ 20000000
`define CTS_ECHO_US 6
`define CTS_ECHO_CYC ((`CTS_CLK_HZ / 1000000) * `CTS_ECHO_US)
`define CTS_ECHO_W 8
`define CTS_CNT_W 16
`define CTS_LINE_ACT 16'h0040
`define CTS_LINE_GAP 16'h0010
`define CTS_FRAME_LINES 16'h0020
`define CTS_FRAME_GAP 16'h0008
`define CTS_EXPO_CYC 16'h0100
`endif

// ---- cts_chk.sv ----
// Assertion checker for the trigger echo, strobe and framing outputs
`timescale 1ns/10ps
`default_nettype none
module cts_chk (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic trig_in_i,
    input wire logic ext_trig_en_i,
    input wire logic slow_rate_i,
    input wire logic strobe_out_o,
    input wire logic trig_echo_o,
    input wire logic line_valid_out_o,
    input wire logic frame_valid_out_o
);
    logic [7:0] e_reg, e_next, l_reg, l_next;
    always_comb begin
        e_next = trig_echo_o ? e_reg + 8'h01 : 8'h00;
        l_next = line_valid_out_o ? l_reg + 8'h01 : 8'h00;
    end
    always_ff @(posedge clk_i) begin
        e_reg <= sys_rst_i ? 8'h00 : e_next;
        l_reg <= sys_rst_i ? 8'h00 : l_next;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    AST_ECHO_RISE: assert property ($fell(trig_in_i) && ext_trig_en_i && $past(ext_trig_en_i, 4)
        |-> ##[2:7] trig_echo_o) else $error("echo late");
    AST_ECHO_LEN: assert property ($fell(trig_echo_o) |-> e_reg == 8'h78) else $error("echo width");
    AST_STB_IDLE: assert property (strobe_out_o |-> !frame_valid_out_o) else $error("strobe late");
    AST_STB_END: assert property ($fell(strobe_out_o) |-> line_valid_out_o) else $error("strobe end");
    AST_LV_IN_FV: assert property (line_valid_out_o |-> frame_valid_out_o) else $error("line alone");
    AST_LINE_LEN: assert property ($fell(line_valid_out_o) |-> l_reg == (slow_rate_i ? 8'h80 : 8'h40))
        else $error("line width");
    AST_LINE_GAP: assert property ($fell(line_valid_out_o) && frame_valid_out_o && !slow_rate_i
        |-> !line_valid_out_o [*8] ##9 line_valid_out_o) else $error("line gap");
    AST_FRAME_END: assert property ($fell(frame_valid_out_o) |-> $fell(line_valid_out_o))
        else $error("frame end");
endmodule
bind cts_top cts_chk i_chk (.clk_i, .sys_rst_i, .trig_in_i, .ext_trig_en_i, .slow_rate_i, .strobe_out_o,
    .trig_echo_o, .line_valid_out_o, .frame_valid_out_o);
`default_nettype wire

// ---- cts_pkg.sv ----
// Types for the camera trigger and sync block
package cts_pkg;
    typedef enum logic [2:0] {
        CTS_IDLE = 3'h0,
        CTS_EXPO = 3'h1,
        CTS_LINE = 3'h3,
        CTS_LGAP = 3'h2,
        CTS_FGAP = 3'h6
    } cts_state_t;
endpackage

// ---- cts_src.sv ----
// External trigger source model driving both trigger inputs
`timescale 1ns/10ps
`default_nettype none
module cts_src (
    input wire logic clk_i,
    input wire logic fire_i,
    input wire logic diff_i,
    output logic trig_o,
    output logic p_o,
    output logic n_o
);
    int hold = 0;
    logic sel = 1'b0;
    always @(posedge clk_i) begin
        hold <= fire_i ? 20 : (hold > 0 ? hold - 1 : 0);
        sel <= fire_i ? diff_i : sel;
    end
    // Low long enough to pass the synchroniser
    assign trig_o = !(hold > 0 && !sel);
    assign p_o = !(hold > 0 && sel);
    assign n_o = hold > 0 && sel;
endmodule
`default_nettype wire

// ---- cts_top.sv ----
// Auxiliary trigger, strobe and framing outputs of the camera
// Summary of operation
// RULE1 - In continuous overlapped mode the strobe is high exactly while the sensor integrates.
// RULE2 - A high-to-low edge on the single-ended trigger starts an exposure.
// RULE3 - A high-to-low change of the differential trigger level starts an exposure.
// RULE4 - Line valid is high through the valid part of every line read out.
// RULE5 - Line valid is low between lines and between frames.
// RULE6 - Each accepted external trigger gives a 6 us positive echo pulse.
// RULE7 - The echo pulse starts at the falling edge of the accepted trigger.
// RULE8 - Frame valid is high while active lines are read and low between frames.
// RULE9 - The readout pixel rate is selectable between a fast and a slow rate.
// RULE10 - Triggers are synchronised before edge detection and the echo width is counted in clocks.
`timescale 1ns/10ps
`default_nettype none
`include "cts_cfg.svh"
module cts_top (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic trig_in_i,
    input wire logic trig_diff_p_i,
    input wire logic trig_diff_n_i,
    input wire logic ext_trig_en_i,
    input wire logic overlap_mode_i,
    input wire logic slow_rate_i,
    output logic strobe_out_o,
    output logic trig_echo_o,
    output logic line_valid_out_o,
    output logic frame_valid_out_o
);
    logic [1:0] trig_pin, trig_fall;
    logic diff_lvl, trig_acc, tick;
    logic [1:0] rate_s_reg, rate_s_next;
    logic [1:0] ext_s_reg, ext_s_next;
    logic [1:0] ovl_s_reg, ovl_s_next;
    logic [1:0] dp_s_reg, dp_s_next;
    logic [1:0] dn_s_reg, dn_s_next;
    logic pace_reg, pace_next;
    logic [`CTS_ECHO_W-1:0] echo_reg, echo_next;
    logic echo_out_reg, echo_out_next;
    cts_pkg::cts_state_t st_reg, st_next;
    logic [`CTS_CNT_W-1:0] cnt_reg, cnt_next, line_reg, line_next;
    logic pend_reg, pend_next;
    logic strobe_reg, strobe_next;
    logic line_valid_out_reg, line_valid_out_next;
    logic fval_reg, fval_next;
    genvar gi;

    // Line valid phase of the readout
    function automatic logic cts_is_line(input cts_pkg::cts_state_t st);
        return st == cts_pkg::CTS_LINE;
    endfunction

    // Frame valid covers the lines and the gaps between them
    function automatic logic cts_in_frame(input cts_pkg::cts_state_t st);
        return cts_is_line(st) | (st == cts_pkg::CTS_LGAP);
    endfunction

    // Level inputs and both legs of the pair pass two flip-flops before use
    always_comb begin
        rate_s_next = {rate_s_reg[0], slow_rate_i};
        ext_s_next = {ext_s_reg[0], ext_trig_en_i};
        ovl_s_next = {ovl_s_reg[0], overlap_mode_i};
        dp_s_next = {dp_s_reg[0], trig_diff_p_i}; // [RULE10]
        dn_s_next = {dn_s_reg[0], trig_diff_n_i}; // [RULE10]
        pace_next = ~pace_reg;
    end

    // The pair resets to its idle level so release gives no false edge
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rate_s_reg <= 2'h0;
            ext_s_reg <= 2'h0;
            ovl_s_reg <= 2'h0;
            dp_s_reg <= 2'h3;
            dn_s_reg <= 2'h0;
            pace_reg <= 1'b0;
        end else begin
            rate_s_reg <= rate_s_next;
            ext_s_reg <= ext_s_next;
            ovl_s_reg <= ovl_s_next;
            dp_s_reg <= dp_s_next;
            dn_s_reg <= dn_s_next;
            pace_reg <= pace_next;
        end
    end

    assign diff_lvl = dp_s_reg[1] & ~dn_s_reg[1]; // [RULE3]
    assign trig_pin = {diff_lvl, trig_in_i};
    // One synchroniser and falling edge detector per trigger source
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_trig
            cts_trig_sync u_sync (
                .clk_i(clk_i),
                .sys_rst_i(sys_rst_i),
                .trig_i(trig_pin[gi]),
                .fall_o(trig_fall[gi])
            ); // [RULE2] [RULE3] [RULE10]
        end
    endgenerate
    assign trig_acc = ext_s_reg[1] & (|trig_fall); // [RULE6]
    // Slow rate advances the readout on every other clock
    assign tick = ~rate_s_reg[1] | pace_reg; // [RULE9]

    // Echo pulse timer counted in clocks
    always_comb begin
        echo_next = echo_reg;
        echo_out_next = echo_out_reg;
        if (trig_acc) begin
            // A trigger during the pulse restarts the count
            echo_next = `CTS_ECHO_W'(`CTS_ECHO_CYC - 1); // [RULE6] [RULE7] [RULE10]
            echo_out_next = 1'b1;
        end else if (echo_reg != '0) begin
            echo_next = echo_reg - 1'b1;
        end else begin
            echo_out_next = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            echo_reg <= '0;
            echo_out_reg <= 1'b0;
        end else begin
            echo_reg <= echo_next;
            echo_out_reg <= echo_out_next;
        end
    end

    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        line_next = line_reg;
        pend_next = pend_reg;
        // A trigger between slow ticks in CTS_IDLE is held until the next tick
        if (tick) begin
            pend_next = 1'b0;
        end else if (trig_acc && (st_reg == cts_pkg::CTS_IDLE)) begin
            pend_next = 1'b1;
        end
        if (tick) begin
            case (st_reg)
                cts_pkg::CTS_IDLE: begin
                    if (trig_acc || pend_reg) begin // [RULE2] [RULE3]
                        st_next = cts_pkg::CTS_EXPO;
                        cnt_next = '0;
                    end
                end
                cts_pkg::CTS_EXPO: begin
                    cnt_next = cnt_reg + 1'b1;
                    if (cnt_reg == `CTS_EXPO_CYC - 1) begin
                        st_next = cts_pkg::CTS_LINE;
                        cnt_next = '0;
                        line_next = '0;
                    end
                end
                cts_pkg::CTS_LINE: begin
                    cnt_next = cnt_reg + 1'b1;
                    if (cnt_reg == `CTS_LINE_ACT - 1) begin
                        cnt_next = '0;
                        line_next = line_reg + 1'b1;
                        st_next = (line_reg == `CTS_FRAME_LINES - 1) ? cts_pkg::CTS_FGAP : cts_pkg::CTS_LGAP;
                    end
                end
                cts_pkg::CTS_LGAP: begin
                    cnt_next = cnt_reg + 1'b1;
                    if (cnt_reg == `CTS_LINE_GAP - 1) begin
                        cnt_next = '0;
                        st_next = cts_pkg::CTS_LINE;
                    end
                end
                cts_pkg::CTS_FGAP: begin
                    cnt_next = cnt_reg + 1'b1;
                    if (cnt_reg == `CTS_FRAME_GAP - 1) begin
                        cnt_next = '0;
                        st_next = cts_pkg::CTS_IDLE;
                    end
                end
                default: begin
                    st_next = cts_pkg::CTS_IDLE;
                    cnt_next = '0;
                end
            endcase
        end
    end

    // Frame sequencer registers
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_reg <= cts_pkg::CTS_IDLE;
            cnt_reg <= '0;
            line_reg <= '0;
            pend_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            line_reg <= line_next;
            pend_reg <= pend_next;
        end
    end

    // Outputs follow the next state so each comes straight from a flip-flop
    always_comb begin
        strobe_next = ovl_s_reg[1] & (st_next == cts_pkg::CTS_EXPO); // [RULE1]
        line_valid_out_next = cts_is_line(st_next); // [RULE4] [RULE5]
        fval_next = cts_in_frame(st_next); // [RULE8]
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            strobe_reg <= 1'b0;
            line_valid_out_reg <= 1'b0;
            fval_reg <= 1'b0;
        end else begin
            strobe_reg <= strobe_next;
            line_valid_out_reg <= line_valid_out_next;
            fval_reg <= fval_next;
        end
    end

    assign strobe_out_o = strobe_reg;
    assign trig_echo_o = echo_out_reg;
    assign line_valid_out_o = line_valid_out_reg;
    assign frame_valid_out_o = fval_reg;
endmodule
`default_nettype wire

// ---- cts_top_test.sv ----
// Self-checking testbench for the camera trigger and sync block
`timescale 1ns/10ps
`default_nettype none
`include "cts_cfg.svh"
module cts_top_test;
    logic clk_i = 1'b0, sys_rst_i = 1'b1, ext_trig_en_i = 1'b0, overlap_mode_i = 1'b0, slow_rate_i = 1'b0;
    logic fire_r = 1'b0, diff_r = 1'b0, t_w, p_w, n_w, strobe_out_o, trig_echo_o, line_valid_out_o;
    logic frame_valid_out_o;
    int err_total = 0, tests_run = 0, seed = 32'h78F23A1D;
    cts_src i_src (.clk_i, .fire_i(fire_r), .diff_i(diff_r), .trig_o(t_w), .p_o(p_w), .n_o(n_w));
    cts_top i_dut (.clk_i, .sys_rst_i, .trig_in_i(t_w), .trig_diff_p_i(p_w), .trig_diff_n_i(n_w),
        .ext_trig_en_i, .overlap_mode_i, .slow_rate_i, .strobe_out_o, .trig_echo_o, .line_valid_out_o,
        .frame_valid_out_o);
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            $display("[FAIL] %s expected %0d seen %0d", nm, exp, seen);
            err_total++;
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    function automatic int ticks(input int n, input logic s);
        return s ? 2 * n : n;
    endfunction
    // An idle camera is fired again, so a lost trigger shows in the fire count
    task automatic run(input logic d, s, o, x, en, input int lim);
        int n, f, e, st, lh, lr;
        logic fr, lv_prev;
        n = 0; f = 0; e = 0; st = 0; lh = 0; lr = 0; lv_prev = 1'b0;
        @(posedge clk_i);
        ext_trig_en_i <= en;
        slow_rate_i <= s;
        overlap_mode_i <= o;
        diff_r <= d;
        repeat (40) @(posedge clk_i);
        while (!(lr > 0 && !frame_valid_out_o) && n < lim) begin
            fr = n == 1 || (x && n == 1500) || (n % 700 == 0 && st + lr == 0 && n > 0 && n < 3000);
            @(posedge clk_i);
            fire_r <= fr;
            f += fr;
            #1;
            n++;
            e += trig_echo_o;
            st += strobe_out_o;
            lh += line_valid_out_o;
            lr += line_valid_out_o && !lv_prev;
            lv_prev = line_valid_out_o;
        end
        if (en && n >= lim) begin
            check("frame end", 0, 1);
            give_verdict();
        end
        check("echo cycles", e, en ? f * `CTS_ECHO_CYC : 0);
        check("triggers", f, 1 + x);
        check("strobe cycles", st, en && o ? ticks(`CTS_EXPO_CYC, s) : 0);
        check("lines", lr, en ? `CTS_FRAME_LINES : 0);
        check("line cycles", lh, en ? ticks(`CTS_FRAME_LINES * `CTS_LINE_ACT, s) : 0);
        $display("test done diff %0d slow %0d overlap %0d retrig %0d en %0d", d, s, o, x, en);
    endtask
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    initial begin
        logic [31:0] r;
        repeat (5) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        run(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 9000);
        run(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 9000);
        run(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 9000);
        run(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 400);
        repeat (3) begin
            r = $random(seed);
            run(r[0], r[1], r[2], r[3], 1'b1, 9000);
        end
        give_verdict();
    end
endmodule
`default_nettype wire

// ---- cts_trig_sync.sv ----
// Trigger input synchroniser and falling edge detector
`timescale 1ns/10ps
`default_nettype none
module cts_trig_sync (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic trig_i,
    output logic fall_o
);
    logic s1_reg, s1_next, s2_reg, s2_next, s3_reg, s3_next, fall_reg, fall_next;
    always_comb begin
        s1_next = trig_i;
        s2_next = s1_reg;
        s3_next = s2_reg;
        fall_next = s3_reg & ~s2_reg;
    end
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
            s3_reg <= 1'b1;
            fall_reg <= 1'b0;
        end else begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
            s3_reg <= s3_next;
            fall_reg <= fall_next;
        end
    end
    assign fall_o = fall_reg;
endmodule
`default_nettype wire
